// file: cpm_classifier.sv
// combinational sort of plug contents into four classes
`timescale 1ns/1ns
`default_nettype none
`include "cpm_defines.svh"
module cpm_classifier
	import cpm_pkg::*;
(
	input  wire cpm_plug_info_t      info,
	input  wire logic [15:0]         ownUnitId,
	output var cpm_class_t           plugClass
);
	always_comb
	begin
		if (!info.valid)
			plugClass = CPM_PLUG_BLANK;
		else if (info.typeId != `CPM_OWN_TYPE_ID)
			plugClass = CPM_PLUG_FOREIGN;
		else if (info.unitId != ownUnitId)
			plugClass = CPM_PLUG_OTHER;
		else
			plugClass = CPM_PLUG_OWN;
	end
endmodule : cpm_classifier
`default_nettype wire

// file: cpm_defines.svh
// timing and field constants, plus the list of behaviours, for the plug manager
// What this block does
// - startup with blank plug copies internal memory
// - configuration change rewrites present plug automatically, except an other-unit plug
// - compatible plug supplies the working configuration
// - factory reset with plug stores defaults there
// - foreign-type plug raises error, enters fault state
// - fault holds until acknowledge; acknowledge copies memory
// - other-unit plug used, never overwritten automatically
// - other-unit copy only on operator transfer command
// - after other-unit start, erase memory next startup
// - fault lamp on: protected mode diagnostic interrupt
// - fault lamp on for internal error
// - bus lamp flashes on broken or inactive master
// - bus lamp flashes on missing or wrong parameters
// - power lamp lit while supplied
// - configuration mode distinct from protected mode
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH
`define CPM_FLASH_HALF_NS 500000000
`define CPM_CLK_NS        50
`define CPM_FLASH_CYCLES  (`CPM_FLASH_HALF_NS / `CPM_CLK_NS)
`define CPM_CNT_W         24
`define CPM_ID_W          16
`define CPM_OWN_TYPE_ID   16'h5a3c
`define CPM_UNIT_ID_W     16
`endif

// file: cpm_lamps.sv
// device-level lamp drivers with flash divider
`timescale 1ns/1ns
`default_nettype none
`include "cpm_defines.svh"
module cpm_lamps
	import cpm_pkg::*;
#(
	parameter int FLASH_CYCLES = `CPM_FLASH_CYCLES
)
(
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire cpm_lamp_in_t lampIn,
	input  wire logic         protectedMode,
	input  wire logic         plugFault,
	output logic              systemFaultLamp_r,
	output logic              busFaultLamp_r,
	output logic              powerLamp_r
);
	logic [`CPM_CNT_W-1:0] flashCnt_r;
	logic [`CPM_CNT_W-1:0] flashCnt_nxt;
	logic                  flashPh_r;
	logic                  flashPh_nxt;
	logic                  sfNxt;
	logic                  bfNxt;
	logic                  busBad;

	always_comb
	begin
		flashCnt_nxt = flashCnt_r + `CPM_CNT_W'(1);
		flashPh_nxt  = flashPh_r;
		if (flashCnt_r == `CPM_CNT_W'(FLASH_CYCLES - 1))
		begin
			flashCnt_nxt = '0;
			flashPh_nxt  = !flashPh_r;
		end
		busBad = lampIn.linkBroken | lampIn.masterInactive
			| lampIn.paramFault;
		bfNxt = busBad & flashPh_r;
		sfNxt = (protectedMode & lampIn.diagInterrupt)
			| lampIn.internalError | plugFault;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			flashCnt_r        <= '0;
			flashPh_r         <= 1'b0;
			systemFaultLamp_r <= 1'b0;
			busFaultLamp_r    <= 1'b0;
			powerLamp_r       <= 1'b1;
		end
		else
		begin
			flashCnt_r        <= flashCnt_nxt;
			flashPh_r         <= flashPh_nxt;
			systemFaultLamp_r <= sfNxt;
			busFaultLamp_r    <= bfNxt;
			powerLamp_r       <= 1'b1;
		end
	end
endmodule : cpm_lamps
`default_nettype wire

// file: cpm_pkg.sv
// types shared by the plug manager modules
package cpm_pkg;
	typedef enum logic [1:0] {
		CPM_PLUG_BLANK,
		CPM_PLUG_FOREIGN,
		CPM_PLUG_OTHER,
		CPM_PLUG_OWN
	} cpm_class_t;

	typedef struct packed {
		logic        present;
		logic        valid;
		logic [15:0] typeId;
		logic [15:0] unitId;
	} cpm_plug_info_t;

	typedef struct packed {
		logic diagInterrupt;
		logic internalError;
		logic linkBroken;
		logic masterInactive;
		logic paramFault;
	} cpm_lamp_in_t;
endpackage : cpm_pkg

// file: cpm_plug_manager.sv
// configuration plug manager: startup source selection, write-back, lamps
`timescale 1ns/1ns
`default_nettype none
`include "cpm_defines.svh"
module cpm_plug_manager
	import cpm_pkg::*;
#(
	parameter int FLASH_CYCLES = `CPM_FLASH_CYCLES
)
(
	input  wire logic           clk_sys,
	input  wire logic           reset,
	input  wire logic           startup,
	input  wire cpm_plug_info_t plugInfo,
	input  wire logic [15:0]    ownUnitId,
	input  wire logic           configChanged,
	input  wire logic           factoryReset,
	input  wire logic           faultAck,
	input  wire logic           transferCmd,
	input  wire logic           copyDone,
	input  wire logic           configModeReq,
	input  wire cpm_lamp_in_t   lampIn,
	output logic                copyMemToPlug_r,
	output logic                copyDefaultsToPlug_r,
	output logic                usePlugConfig_r,
	output logic                eraseInternal_r,
	output logic                plugFault_r,
	output logic                plugError_r,
	output logic                operational_r,
	output logic                configMode_r,
	output logic                systemFaultLamp_r,
	output logic                busFaultLamp_r,
	output logic                powerLamp_r
);
	typedef enum logic [2:0] {
		CPM_IDLE,
		CPM_CLASSIFY,
		CPM_FAULT,
		CPM_RUN,
		CPM_COPY
	} cpm_state_t;

	cpm_state_t state_r;
	cpm_state_t state_nxt;
	cpm_class_t plugClass;
	logic       copyMem_nxt;
	logic       copyDef_nxt;
	logic       usePlug_nxt;
	logic       erase_nxt;
	logic       fault_nxt;
	logic       err_nxt;
	logic       oper_nxt;
	logic       cfgMode_nxt;
	logic       eraseArmed_r;
	logic       eraseArmed_nxt;
	logic       foreignPlug_r;
	logic       foreignPlug_nxt;
	logic       pendChange_r;
	logic       pendChange_nxt;

	cpm_classifier u_class (
		.info      (plugInfo),
		.ownUnitId (ownUnitId),
		.plugClass (plugClass)
	);

	cpm_lamps #(
		.FLASH_CYCLES (FLASH_CYCLES)
	) u_lamps (
		.clk_sys           (clk_sys),
		.reset             (reset),
		.lampIn            (lampIn),
		.protectedMode     (!configMode_r),
		.plugFault         (plugFault_r),
		.systemFaultLamp_r (systemFaultLamp_r),
		.busFaultLamp_r    (busFaultLamp_r),
		.powerLamp_r       (powerLamp_r)
	);

	always_comb
	begin
		state_nxt       = state_r;
		copyMem_nxt     = 1'b0;
		copyDef_nxt     = 1'b0;
		erase_nxt       = 1'b0;
		usePlug_nxt     = usePlugConfig_r;
		fault_nxt       = plugFault_r;
		err_nxt         = 1'b0;
		oper_nxt        = operational_r;
		cfgMode_nxt     = configModeReq;
		eraseArmed_nxt  = eraseArmed_r;
		foreignPlug_nxt = foreignPlug_r;
		pendChange_nxt  = pendChange_r | (configChanged & plugInfo.present);
		case (state_r)
		CPM_IDLE:
			if (startup)
				state_nxt = CPM_CLASSIFY;
		CPM_CLASSIFY:
		begin
			// erase belongs to the startup after an other-unit start
			if (eraseArmed_r)
			begin
				erase_nxt      = 1'b1;
				eraseArmed_nxt = 1'b0;
			end
			usePlug_nxt     = 1'b0;
			foreignPlug_nxt = 1'b0;
			pendChange_nxt  = 1'b0;
			oper_nxt        = 1'b1;
			state_nxt       = CPM_RUN;
			if (plugInfo.present)
			begin
				case (plugClass)
				CPM_PLUG_BLANK:
				begin
					copyMem_nxt = 1'b1;
					state_nxt   = CPM_COPY;
				end
				CPM_PLUG_FOREIGN:
				begin
					err_nxt   = 1'b1;
					fault_nxt = 1'b1;
					oper_nxt  = 1'b0;
					state_nxt = CPM_FAULT;
				end
				CPM_PLUG_OTHER:
				begin
					usePlug_nxt     = 1'b1;
					foreignPlug_nxt = 1'b1;
					eraseArmed_nxt  = 1'b1;
				end
				CPM_PLUG_OWN:
					usePlug_nxt = 1'b1;
				default:
					state_nxt = CPM_RUN;
				endcase
			end
			// a fault still waiting for its acknowledge survives a restart
			if (plugFault_r)
			begin
				copyMem_nxt = 1'b0;
				oper_nxt    = 1'b0;
				state_nxt   = CPM_FAULT;
			end
		end
		CPM_FAULT:
			if (faultAck)
			begin
				fault_nxt   = 1'b0;
				oper_nxt    = 1'b1;
				copyMem_nxt = 1'b1;
				state_nxt   = CPM_COPY;
			end
		CPM_RUN:
			if (factoryReset && plugInfo.present)
			begin
				copyDef_nxt    = 1'b1;
				pendChange_nxt = 1'b0;
				state_nxt      = CPM_COPY;
			end
			else if (transferCmd && foreignPlug_r && plugInfo.present)
			begin
				copyMem_nxt     = 1'b1;
				foreignPlug_nxt = 1'b0;
				pendChange_nxt  = 1'b0;
				state_nxt       = CPM_COPY;
			end
			else if (pendChange_r && !foreignPlug_r && !plugFault_r)
			begin
				copyMem_nxt    = 1'b1;
				pendChange_nxt = 1'b0;
				state_nxt      = CPM_COPY;
			end
		CPM_COPY:
			if (copyDone)
				state_nxt = CPM_RUN;
		default:
			state_nxt = CPM_IDLE;
		endcase
		if (startup && state_r != CPM_IDLE)
			state_nxt = CPM_CLASSIFY;
		// a change in the same cycle as a clear must not be lost
		if (configChanged && plugInfo.present)
			pendChange_nxt = 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_r              <= CPM_IDLE;
			copyMemToPlug_r      <= 1'b0;
			copyDefaultsToPlug_r <= 1'b0;
			usePlugConfig_r      <= 1'b0;
			eraseInternal_r      <= 1'b0;
			plugFault_r          <= 1'b0;
			plugError_r          <= 1'b0;
			operational_r        <= 1'b0;
			configMode_r         <= 1'b0;
			eraseArmed_r         <= 1'b0;
			foreignPlug_r        <= 1'b0;
			pendChange_r         <= 1'b0;
		end
		else
		begin
			state_r              <= state_nxt;
			copyMemToPlug_r      <= copyMem_nxt;
			copyDefaultsToPlug_r <= copyDef_nxt;
			usePlugConfig_r      <= usePlug_nxt;
			eraseInternal_r      <= erase_nxt;
			plugFault_r          <= fault_nxt;
			plugError_r          <= err_nxt;
			operational_r        <= oper_nxt;
			configMode_r         <= cfgMode_nxt;
			eraseArmed_r         <= eraseArmed_nxt;
			foreignPlug_r        <= foreignPlug_nxt;
			pendChange_r         <= pendChange_nxt;
		end
	end
endmodule : cpm_plug_manager
`default_nettype wire

// file: cpm_plug_manager_checker.sv
// port assertions for the configuration plug manager
`timescale 1ns/1ns
`default_nettype none
`include "cpm_defines.svh"
module cpm_plug_manager_checker
	import cpm_pkg::*;
(
	input wire logic           clk_sys,
	input wire logic           reset,
	input wire logic           startup,
	input wire cpm_plug_info_t plugInfo,
	input wire logic [15:0]    ownUnitId,
	input wire logic           faultAck,
	input wire cpm_lamp_in_t   lampIn,
	input wire logic           copyMemToPlug_r,
	input wire logic           copyDefaultsToPlug_r,
	input wire logic           plugFault_r,
	input wire logic           plugError_r,
	input wire logic           configMode_r,
	input wire logic           systemFaultLamp_r,
	input wire logic           busFaultLamp_r
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire logic ok     = plugInfo.present & plugInfo.valid;
	wire logic ownT   = plugInfo.typeId == `CPM_OWN_TYPE_ID;
	wire logic busBad = lampIn.linkBroken | lampIn.masterInactive
		| lampIn.paramFault;
	a_blank_copy:
	assert property (startup & plugInfo.present & !plugInfo.valid
		|-> ##[1:3] copyMemToPlug_r) else $error("blank plug not filled");
	a_foreign_fault:
	assert property (startup & ok & !ownT |-> ##[1:3] plugFault_r & plugError_r)
		else $error("foreign plug not flagged");
	a_other_keep:
	assert property (startup & ok & ownT & plugInfo.unitId != ownUnitId
		|-> ##1 !copyMemToPlug_r [*4]) else $error("other plug overwritten");
	a_fault_hold:
	assert property (plugFault_r & !faultAck & !startup |=> plugFault_r)
		else $error("fault left without ack");
	a_ack_copy:
	assert property (plugFault_r & faultAck |=> !plugFault_r & copyMemToPlug_r)
		else $error("ack did not clear and copy");
	a_fault_no_write:
	assert property (plugFault_r |-> !copyMemToPlug_r & !copyDefaultsToPlug_r)
		else $error("plug written during fault");
	a_sys_lamp:
	assert property (!$past(reset) |-> systemFaultLamp_r ==
		((!$past(configMode_r) & $past(lampIn.diagInterrupt))
		| $past(lampIn.internalError) | $past(plugFault_r)))
		else $error("system lamp wrong");
	a_bus_idle:
	assert property (!$past(busBad) |-> !busFaultLamp_r)
		else $error("bus lamp lit without cause");
	cover property (plugFault_r & faultAck);
	cover property (startup & ok & ownT);
	cover property (busFaultLamp_r);
	cover property (startup & ok & ownT & plugInfo.unitId != ownUnitId);
endmodule : cpm_plug_manager_checker
bind cpm_plug_manager cpm_plug_manager_checker i_chk (.*);
`default_nettype wire

// file: cpm_plug_model.sv
// behavioural configuration plug: contents and copy completion
`timescale 1ns/1ns
`default_nettype none
`include "cpm_defines.svh"
module cpm_plug_model
	import cpm_pkg::*;
(
	input  wire logic           clk_sys,
	input  wire logic           load,
	input  wire cpm_plug_info_t loadInfo,
	input  wire logic [15:0]    ownUnitId,
	input  wire logic [3:0]     writeDelay,
	input  wire logic           copyMemToPlug_r,
	input  wire logic           copyDefaultsToPlug_r,
	output var cpm_plug_info_t  plugInfo,
	output logic                copyDone = 1'h0
);
	cpm_plug_info_t store   = '0;
	logic [31:0]    junk    = '0;
	int             waitCnt = 0;
	// an empty slot reads back churning bits, never a stale image
	assign plugInfo = store.present ? store : {2'h0, junk};
	always @(posedge clk_sys)
	begin
		junk <= ~junk;
		copyDone <= (waitCnt == 1);
		if (copyMemToPlug_r | copyDefaultsToPlug_r)
			waitCnt <= writeDelay + 1;
		else if (waitCnt != 0)
			waitCnt <= waitCnt - 1;
		if (load)
			store <= loadInfo;
		else if (waitCnt == 1)
			store <= {2'h3, `CPM_OWN_TYPE_ID, ownUnitId};
	end
endmodule : cpm_plug_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the configuration plug manager
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import cpm_pkg::*;
	localparam logic [4:0]  ST = 5'h10, CH = 5'h08, FR = 5'h04;
	localparam logic [4:0]  ACK = 5'h02, TR = 5'h01;
	localparam logic [15:0] OWN_T = 16'h5a3c;
	logic           clk_sys = '0, reset = '1, load = '0, configModeReq = '0;
	logic [4:0]     cmd = '0;
	logic [3:0]     writeDelay = '0;
	logic [15:0]    ownUnitId = 16'h0101;
	logic [31:0]    rnd = 32'h27d2;
	cpm_plug_info_t loadInfo = '0, plugInfo;
	cpm_lamp_in_t   lampIn = '0;
	logic           copyDone, copyMemToPlug_r, copyDefaultsToPlug_r;
	logic           usePlugConfig_r, eraseInternal_r, plugFault_r;
	logic           plugError_r, operational_r, configMode_r, prevB;
	logic           systemFaultLamp_r, busFaultLamp_r, powerLamp_r;
	wire logic      startup = cmd[4], configChanged = cmd[3];
	wire logic      factoryReset = cmd[2], faultAck = cmd[1];
	wire logic      transferCmd = cmd[0];
	int             miscompares = 0, checkCount = 0, tog, i;
	int             eC = 0, eD = 0, eE = 0, eR = 0, nC = 0, nD = 0, nE = 0;
	int             nR = 0;
	bit             expL, cmOld = 0;
	cpm_plug_manager #(.FLASH_CYCLES(4)) i_cpm_plug_manager (.*);
	cpm_plug_model i_cpm_plug_model (.*);
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		nC += copyMemToPlug_r === '1;
		nD += copyDefaultsToPlug_r === '1;
		nE += eraseInternal_r === '1;
		nR += plugError_r === '1;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input bit ok, input string m);
		checkCount++;
		if (!ok)
			$display("MISMATCH %0t %s", $time, m);
		miscompares += !ok;
	endtask : chk
	task automatic cmp(input string t);
		chk(nC == eC && nD == eD && nE == eE && nR == eR, t);
		$display("test %s done", t);
	endtask : cmp
	// settle long enough for two slow plug writes back to back
	task automatic go(input logic [4:0] c);
		@(posedge clk_sys) cmd <= c;
		@(posedge clk_sys) cmd <= '0;
		repeat (16) @(posedge clk_sys);
		#1;
	endtask : go
	task automatic plug(input logic v, input logic [15:0] t, u);
		rnd = lfsr(rnd);
		@(posedge clk_sys) load <= '1;
		loadInfo <= {1'h1, v, t, u};
		writeDelay <= rnd[3:0] & 4'h3;
		@(posedge clk_sys) load <= '0;
	endtask : plug
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	initial
	begin
		#(50 * 4000);
		miscompares++;
		$display("MISMATCH %0t timeout", $time);
		complete_run;
	end
	initial
	begin
		repeat (5) @(posedge clk_sys);
		reset <= '0;
		plug('0, OWN_T, ownUnitId);
		go(ST);
		eC++;
		chk(operational_r === '1, "blank start");
		cmp("blank");
		go(CH);
		eC++;
		cmp("change");
		go(ST);
		chk(usePlugConfig_r === '1, "own plug");
		go(TR);
		go(FR);
		eD++;
		cmp("own");
		plug('1, OWN_T ^ (rnd[15:0] | 16'h1), ownUnitId);
		go(ST);
		eR++;
		go(CH);
		chk(plugFault_r === '1 && operational_r === '0, "fault");
		chk(systemFaultLamp_r === '1, "fault lamp");
		go(ACK);
		eC += 2;
		chk(plugFault_r === '0, "ack");
		cmp("foreign");
		plug('1, OWN_T, ownUnitId ^ 16'h0100);
		go(ST);
		chk(usePlugConfig_r === '1 && operational_r === '1, "other");
		go(CH);
		cmp("other");
		go(TR);
		eC++;
		go(ST);
		eE++;
		cmp("transfer");
		@(posedge clk_sys) load <= '1;
		loadInfo <= '0;
		@(posedge clk_sys) load <= '0;
		go(ST);
		chk(usePlugConfig_r === '0 && operational_r === '1, "no plug");
		go(CH);
		go(FR);
		cmp("empty slot");
		repeat (40)
		begin
			@(posedge clk_sys);
			expL = (!cmOld & lampIn.diagInterrupt) | lampIn.internalError;
			cmOld = configModeReq;
			rnd = lfsr(rnd);
			lampIn <= rnd[4:0];
			configModeReq <= rnd[5];
			#1;
			chk(systemFaultLamp_r === expL, "sys lamp");
			chk(configMode_r === cmOld && powerLamp_r === '1, "mode");
		end
		$display("test lamps done");
		for (i = 0; i < 3; i++)
		begin
			@(posedge clk_sys);
			lampIn <= 5'h4 >> i;
			tog = 0;
			repeat (24)
			begin
				@(posedge clk_sys);
				#1;
				tog += busFaultLamp_r !== prevB;
				prevB = busFaultLamp_r;
			end
			chk(tog >= 4 && tog <= 8, "bus flash");
		end
		lampIn <= '0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(busFaultLamp_r === '0, "bus idle");
		$display("test flash done");
		complete_run;
	end
endmodule : tb_top
`default_nettype wire
